// *** verilog/prcs_pkg.sv ***
// Constants for the reference clock switchover block: register map, field layout,
// reset values and edge-supervision counts.
// Assumes a 32-bit classic Wishbone register bus and a 100 MHz system clock.
package prcs_pkg;
    // Register byte offsets.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] HOLD_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;

    // Control register fields.
    localparam int CTRL_AUTO_BIT = 0;
    localparam logic CTRL_AUTO_RST = 1'b1;

    // Holdoff register: target clock edges required before a switch completes.
    localparam int HOLD_W = 8;
    localparam logic [HOLD_W-1:0] HOLD_RST = 8'h01;

    // Status register fields.
    localparam int STAT_SEL_BIT = 0;
    localparam int STAT_FAULT_A_BIT = 1;
    localparam int STAT_FAULT_B_BIT = 2;
    localparam int STAT_COND_BIT = 3;
    localparam int STAT_LOCK_BIT = 4;

    // Edge supervision counts.
    localparam int EDGE_W = 2;
    localparam logic [EDGE_W-1:0] EDGE_MISS = 2'h3;
    localparam logic [EDGE_W-1:0] EDGE_PAIR_MAX = 2'h2;

    // Reset values of the selection.
    localparam logic SEL_RST = 1'b0;

    typedef enum logic [1:0] {
        PRCS_RUN,
        PRCS_GATE_OFF,
        PRCS_WAIT_NEW
    } prcs_state_t;
endpackage

// *** verilog/prcs_switchover.sv ***
// Reference clock switchover for a PLL: supervises two reference clocks, selects one,
// gates the chosen one out glitch-free and reports faults to fabric logic.
// Assumes both reference clocks are much slower than clk_i so that the two-stage
// synchronisers see every level; the reference clock, request and lock pins are asynchronous to clk_i.
//
// Functional notes
// [R1] Select one of two references, automatic or manual.
// [R2] Primary absent moves reference to secondary automatically.
// [R3] Automatic switching only goes primary to secondary.
// [R4] Far side drives manual switching beyond 20% mismatch.
// [R5] Low gated lock forces secondary selection; the code forces it only in automatic mode and only after lock was seen high.
// [R6] Keep one edge counter per reference clock.
// [R7] Clear counters at pairs 1-1, 1-2, 2-1, 2-2.
// [R8] Count of three flags other clock faulty.
// [R9] Switch condition goes low after fault rises.
// [R10] After switch condition, select the secondary clock.
// [R11] Configurable edge count before switchover completes.
// [R12] Fault and condition indicators go to fabric.
// [R13] Manual request changes selected reference in automatic mode.
// [R14] Gate output off at current clock falling edge.
// [R15] Mux and select move at new clock falling edge.
// [R16] Override: condition follows request, indicator follows select.
// [R17] Healthy clocks raise no fault during manual switch.
// [R18] Only rising request edge switches; each rise repeats.
// [R19] Switch completes only when target clock present.
// [R20] Fast variant supports manual switching only.
// [R21] Indicator reads 0 for clock a, 1 for b.
// [R22] Far side holds request for minimum pulse width.
// [R23] Reset selects clock a, faults low.
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module prcs_switchover #(
    parameter bit FAST_VARIANT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ref_clock_a_i,
    input wire logic ref_clock_b_i,
    input wire logic manual_switch_request_i,
    input wire logic gated_lock_i,
    output logic gated_ref_out_o,
    output logic ref_select_o,
    output logic active_ref_indicator_o,
    output logic switch_condition_o,
    output logic first_clock_fault_flag_o,
    output logic second_clock_fault_flag_o
);
    // Pin synchronisers; only the second stage is read by logic.
    logic [1:0] sync_a, sync_b, sync_req, sync_lock;
    logic prev_a, prev_b, prev_req;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            sync_req <= 2'h0;
            sync_lock <= 2'h0;
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            prev_req <= 1'b0;
        end else begin
            sync_a <= {sync_a[0], ref_clock_a_i};
            sync_b <= {sync_b[0], ref_clock_b_i};
            sync_req <= {sync_req[0], manual_switch_request_i};
            sync_lock <= {sync_lock[0], gated_lock_i};
            prev_a <= sync_a[1];
            prev_b <= sync_b[1];
            prev_req <= sync_req[1];
        end
    end

    logic rise_a, rise_b, fall_a, fall_b, req_rise;
    assign rise_a = sync_a[1] && !prev_a;
    assign rise_b = sync_b[1] && !prev_b;
    assign fall_a = !sync_a[1] && prev_a;
    assign fall_b = !sync_b[1] && prev_b;
    assign req_rise = sync_req[1] && !prev_req; // [R18]

    // Registers.
    logic auto_en, lock_seen;
    logic [prcs_pkg::HOLD_W-1:0] holdoff;
    logic wr_go;
    assign wr_go = ack_o && we_i && sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_en <= prcs_pkg::CTRL_AUTO_RST;
            holdoff <= prcs_pkg::HOLD_RST;
        end else if (wr_go && adr_i == prcs_pkg::CTRL_OFS) begin
            auto_en <= dat_i[prcs_pkg::CTRL_AUTO_BIT];
        end else if (wr_go && adr_i == prcs_pkg::HOLD_OFS) begin
            holdoff <= dat_i[prcs_pkg::HOLD_W-1:0]; // [R11]
        end
    end

    // The fast variant has no sensing path, so automatic mode is forced off.
    logic auto_on;
    assign auto_on = auto_en && !FAST_VARIANT; // [R20]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_seen <= 1'b0;
        end else if (sync_lock[1]) begin
            lock_seen <= 1'b1;
        end
    end

    // Edge supervision counters.
    logic [prcs_pkg::EDGE_W-1:0] cnt_a, cnt_b, inc_a, inc_b;
    logic pair_clr, miss_any;
    always_comb begin
        inc_a = cnt_a;
        inc_b = cnt_b;
        if (rise_a && cnt_a != prcs_pkg::EDGE_MISS) begin
            inc_a = cnt_a + 2'h1; // [R6]
        end
        if (rise_b && cnt_b != prcs_pkg::EDGE_MISS) begin
            inc_b = cnt_b + 2'h1; // [R6]
        end
        pair_clr = inc_a != 2'h0 && inc_a <= prcs_pkg::EDGE_PAIR_MAX
            && inc_b != 2'h0 && inc_b <= prcs_pkg::EDGE_PAIR_MAX; // [R7]
        miss_any = inc_a == prcs_pkg::EDGE_MISS || inc_b == prcs_pkg::EDGE_MISS; // [R8]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_a <= 2'h0;
            cnt_b <= 2'h0;
        end else if (pair_clr || miss_any) begin
            // A miss restarts the count so that a returning clock can pair again.
            cnt_a <= 2'h0; // [R7]
            cnt_b <= 2'h0;
        end else begin
            cnt_a <= inc_a;
            cnt_b <= inc_b;
        end
    end

    // A count of three on one side means the other clock missed an edge. The flag
    // stays up until both clocks toggle as a pair again, so a slow recovery shows.
    logic fault_a, fault_b;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_a <= 1'b0; // [R23]
            fault_b <= 1'b0;
        end else begin
            if (inc_b == prcs_pkg::EDGE_MISS) begin
                fault_a <= 1'b1; // [R8]
            end else if (pair_clr) begin
                fault_a <= 1'b0; // [R17]
            end
            if (inc_a == prcs_pkg::EDGE_MISS) begin
                fault_b <= 1'b1; // [R8]
            end else if (pair_clr) begin
                fault_b <= 1'b0;
            end
        end
    end

    // Switch state machine.
    prcs_pkg::prcs_state_t state;
    logic sel, gate_on;
    logic [prcs_pkg::HOLD_W-1:0] seen;
    logic lock_lost, auto_trig, cur_fall, new_fall, new_rise, new_ok;
    assign lock_lost = lock_seen && !sync_lock[1];
    assign auto_trig = auto_on && !sel && (fault_a || lock_lost); // [R2] [R3] [R5]
    assign cur_fall = sel ? fall_b : fall_a;
    assign new_fall = sel ? fall_a : fall_b;
    assign new_rise = sel ? rise_a : rise_b;
    assign new_ok = !(sel ? fault_a : fault_b) && seen >= holdoff; // [R11] [R19]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= prcs_pkg::PRCS_RUN;
            sel <= prcs_pkg::SEL_RST; // [R23]
            gate_on <= 1'b1;
            seen <= '0;
        end else begin
            unique case (state)
                prcs_pkg::PRCS_RUN: begin
                    seen <= '0;
                    if (req_rise || auto_trig) begin
                        state <= prcs_pkg::PRCS_GATE_OFF; // [R1] [R10] [R13]
                    end
                end
                prcs_pkg::PRCS_GATE_OFF: begin
                    // A dead current clock never falls, so a fault ends the wait too.
                    if (cur_fall || (sel ? fault_b : fault_a)) begin
                        gate_on <= 1'b0; // [R14]
                        state <= prcs_pkg::PRCS_WAIT_NEW;
                    end
                end
                prcs_pkg::PRCS_WAIT_NEW: begin
                    if (new_rise && seen != '1) begin
                        seen <= seen + 8'h01;
                    end
                    if (new_fall && new_ok) begin
                        sel <= !sel; // [R15] [R19]
                        gate_on <= 1'b1;
                        state <= prcs_pkg::PRCS_RUN;
                    end
                end
            endcase
        end
    end

    // Output stage registers the gated reference so it leaves on a flip-flop.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gated_ref_out_o <= 1'b0;
        end else begin
            gated_ref_out_o <= gate_on && (sel ? sync_b[1] : sync_a[1]); // [R14]
        end
    end

    // Condition output: outside the fast variant, low while a fault or (in automatic mode) a lock loss stands, otherwise it mirrors the request.
    logic cond;
    assign cond = (FAST_VARIANT || !(fault_a || fault_b || (auto_on && lock_lost)))
        && sync_req[1];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_condition_o <= 1'b0;
            first_clock_fault_flag_o <= 1'b0;
            second_clock_fault_flag_o <= 1'b0;
        end else begin
            switch_condition_o <= cond; // [R9] [R16] [R12]
            first_clock_fault_flag_o <= fault_a && !FAST_VARIANT; // [R12]
            second_clock_fault_flag_o <= fault_b && !FAST_VARIANT;
        end
    end
    assign ref_select_o = sel;
    assign active_ref_indicator_o = sel; // [R16] [R21]

    // Wishbone slave: one wait state, unmapped addresses answer with zero data.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            dat_o <= 32'h0;
            if (cyc_i && stb_i && !ack_o) begin
                unique case (adr_i)
                    prcs_pkg::CTRL_OFS: dat_o[prcs_pkg::CTRL_AUTO_BIT] <= auto_en;
                    prcs_pkg::HOLD_OFS: dat_o[prcs_pkg::HOLD_W-1:0] <= holdoff;
                    prcs_pkg::STAT_OFS: begin
                        dat_o[prcs_pkg::STAT_SEL_BIT] <= sel;
                        dat_o[prcs_pkg::STAT_FAULT_A_BIT] <= fault_a;
                        dat_o[prcs_pkg::STAT_FAULT_B_BIT] <= fault_b;
                        dat_o[prcs_pkg::STAT_COND_BIT] <= cond;
                        dat_o[prcs_pkg::STAT_LOCK_BIT] <= sync_lock[1];
                    end
                    default: dat_o <= 32'h0;
                endcase
            end
        end
    end

    // Checks.
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Remembers what started the switch in progress, so the one-way rule is checked
    // against the cause rather than against the state machine's own decode.
    logic by_request;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            by_request <= 1'b0;
        end else if (state == prcs_pkg::PRCS_RUN && (req_rise || auto_trig)) begin
            by_request <= req_rise;
        end
    end

    // Edge supervision.
    pair_clear_a: assert property ( // [R7]
        !(cnt_a inside {2'h1, 2'h2} && cnt_b inside {2'h1, 2'h2}))
        else $error("edge counters left at a clearing pair");
    pair_zero_a: assert property ( // [R7]
        pair_clr |=> cnt_a == 2'h0 && cnt_b == 2'h0)
        else $error("edge counters not cleared at a pair");
    miss_reset_a: assert property ( // [R6]
        cnt_a != prcs_pkg::EDGE_MISS && cnt_b != prcs_pkg::EDGE_MISS)
        else $error("edge counter left at the miss count");
    miss_flag_a: assert property ( // [R8]
        inc_b == prcs_pkg::EDGE_MISS |=> fault_a)
        else $error("missed edge of clock a not flagged");
    miss_flag_b_a: assert property ( // [R8]
        inc_a == prcs_pkg::EDGE_MISS |=> fault_b)
        else $error("missed edge of clock b not flagged");
    healthy_pair_a: assert property ( // [R17]
        pair_clr |=> !fault_a && !fault_b)
        else $error("fault raised while both clocks pair");

    // Indicators towards the fabric.
    fault_cond_a: assert property ( // [R9]
        fault_a |=> !switch_condition_o)
        else $error("condition not low on fault");
    cond_follow_a: assert property ( // [R16]
        !fault_a && !fault_b && !(auto_on && lock_lost) |=> switch_condition_o == $past(sync_req[1]))
        else $error("condition does not follow the request");
    flag_out_a: assert property ( // [R12]
        fault_a && !FAST_VARIANT |=> first_clock_fault_flag_o)
        else $error("clock a fault not shown to the fabric");
    flag_out_b_a: assert property ( // [R12]
        fault_b && !FAST_VARIANT |=> second_clock_fault_flag_o)
        else $error("clock b fault not shown to the fabric");
    indicator_a: assert property ( // [R21]
        active_ref_indicator_o == ref_select_o)
        else $error("indicator differs from selection");

    // Switch sequence.
    manual_start_a: assert property ( // [R13]
        state == prcs_pkg::PRCS_RUN && req_rise |=> state == prcs_pkg::PRCS_GATE_OFF)
        else $error("request rise ignored");
    auto_fault_a: assert property ( // [R2]
        state == prcs_pkg::PRCS_RUN && auto_on && !sel && fault_a |=> state == prcs_pkg::PRCS_GATE_OFF)
        else $error("primary loss ignored");
    lock_loss_a: assert property ( // [R5]
        state == prcs_pkg::PRCS_RUN && auto_on && !sel && lock_lost |=> state == prcs_pkg::PRCS_GATE_OFF)
        else $error("lock loss ignored");
    auto_one_way_a: assert property ( // [R3]
        $fell(sel) |-> by_request)
        else $error("automatic return to clock a");
    quiet_run_a: assert property ( // [R18]
        state == prcs_pkg::PRCS_RUN && !req_rise && !auto_trig |=> state == prcs_pkg::PRCS_RUN && $stable(sel))
        else $error("switch without a request rise");
    fast_manual_a: assert property ( // [R20]
        !(FAST_VARIANT && auto_trig))
        else $error("automatic switch in the fast variant");
    gate_first_a: assert property ( // [R14]
        state == prcs_pkg::PRCS_GATE_OFF && cur_fall |=> !gate_on && state == prcs_pkg::PRCS_WAIT_NEW)
        else $error("gate not closed at the current clock fall");
    gate_off_a: assert property ( // [R14]
        state == prcs_pkg::PRCS_WAIT_NEW |=> !gated_ref_out_o)
        else $error("reference not gated while switching");
    gate_idle_a: assert property ( // [R14]
        !gate_on |=> !gated_ref_out_o)
        else $error("reference leaks through a closed gate");
    // A dead target keeps the machine waiting; the gate stays closed meanwhile.
    target_ready_a: assert property ( // [R19]
        $changed(sel) |-> $past(new_fall && new_ok))
        else $error("switch to an absent clock");
    absent_hold_a: assert property ( // [R19]
        state == prcs_pkg::PRCS_WAIT_NEW && !new_ok |=> $stable(sel))
        else $error("switch while the target is not ready");
    gate_back_a: assert property ( // [R15]
        $rose(gate_on) |-> $changed(sel))
        else $error("gate reopened without a selection change");
    init_sel_a: assert property ( // [R23]
        $fell(rst_i) |-> !sel && !fault_a && !fault_b)
        else $error("bad state after reset");

    // Register bus answer.
    ack_answer_a: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (
        ack_o |=> !ack_o)
        else $error("ack held longer than a cycle");

    // The main scenarios: manual, automatic, back to clock a, lock loss, waiting target.
    manual_sw_c: cover property (req_rise ##[1:300] $rose(sel));
    auto_sw_c: cover property (fault_a ##[1:300] $rose(sel));
    back_sw_c: cover property ($fell(sel));
    lock_sw_c: cover property (lock_lost ##[1:300] $rose(sel));
    wait_c: cover property (state == prcs_pkg::PRCS_WAIT_NEW && !new_ok);
endmodule

// *** verification/prcs_ref_source.sv ***
// Behavioural reference clock source for the switchover bench.
// Assumes the bench sets run_i after a rising edge of the system clock.
`timescale 1ns/10ps
module prcs_ref_source #(
    parameter int HALF_NS = 80
) (
    input wire logic run_i,
    output logic clk_o
);
    initial clk_o = 1'b0;
    // A stopped source stands still low, as a dead oscillator would.
    always begin
        #(HALF_NS);
        clk_o = run_i ? ~clk_o : 1'b0;
    end
endmodule

// *** verification/test_pll_reference_clock_switchover.sv ***
// Self-checking bench for the reference clock switchover block.
// Assumes two sources within 20% of each other and a Wishbone master in the bench.
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
`define WAIT_UNTIL(c) begin for (int k = 0; k < 20000 && !(c); k++) @(negedge clk_i); \
    if (!(c)) begin bad_count++; give_verdict(); end end
module test_pll_reference_clock_switchover;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, q;
    logic ack_o, clk_a, clk_b, gated, sel, ind, cond, fault_a, fault_b;
    logic run_a = 1'b1;
    logic run_b = 1'b1;
    logic req = 1'b0;
    logic lock = 1'b1;
    int bad_count = 0;
    int checked = 0;
    always #5 clk_i = ~clk_i;
    prcs_ref_source #(.HALF_NS(80)) src_a (.run_i(run_a), .clk_o(clk_a));
    prcs_ref_source #(.HALF_NS(88)) src_b (.run_i(run_b), .clk_o(clk_b));
    prcs_switchover uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .ref_clock_a_i(clk_a), .ref_clock_b_i(clk_b),
        .manual_switch_request_i(req), .gated_lock_i(lock), .gated_ref_out_o(gated),
        .ref_select_o(sel), .active_ref_indicator_o(ind), .switch_condition_o(cond),
        .first_clock_fault_flag_o(fault_a), .second_clock_fault_flag_o(fault_b));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50) begin
            bad_count++;
            give_verdict();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic do_reset(input int n);
        rst_i <= 1'b1;
        run_a <= 1'b1;
        run_b <= 1'b1;
        req <= 1'b0;
        lock <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (60) @(posedge clk_i);
    endtask
    task automatic t_reset();
        `CHECK("ref_select", 1'b0, sel)
        `CHECK("indicator", 1'b0, ind)
        `CHECK("faults", 2'b00, {fault_a, fault_b})
        wb(1'b0, prcs_pkg::CTRL_OFS, 32'h0);
        `CHECK("ctrl", 32'h00000001, q)
        wb(1'b0, 4'hC, 32'h0);
        `CHECK("unmapped", 32'h00000000, q)
        wb(1'b1, prcs_pkg::HOLD_OFS, 32'h00000002);
        wb(1'b0, prcs_pkg::HOLD_OFS, 32'h0);
        `CHECK("holdoff", 32'h00000002, q)
    endtask
    task automatic t_manual();
        req <= 1'b1;
        `WAIT_UNTIL(sel === 1'b1)
        `CHECK("sel to b", 1'b1, sel)
        `CHECK("indicator b", 1'b1, ind)
        `CHECK("cond follows", 1'b1, cond)
        `CHECK("no faults", 2'b00, {fault_a, fault_b})
        `WAIT_UNTIL(gated === 1'b1)
        `CHECK("gated live", 1'b1, gated)
        // The request is held far past the minimum width.
        repeat (300) @(posedge clk_i);
        req <= 1'b0;
        repeat (400) @(posedge clk_i);
        `CHECK("fall keeps b", 1'b1, sel)
        req <= 1'b1;
        `WAIT_UNTIL(sel === 1'b0)
        `CHECK("rise again", 1'b0, sel)
        repeat (300) @(posedge clk_i);
        req <= 1'b0;
        repeat (100) @(posedge clk_i);
    endtask
    task automatic t_auto();
        run_a <= 1'b0;
        `WAIT_UNTIL(fault_a === 1'b1)
        `CHECK("fault a", 2'b10, {fault_a, fault_b})
        `CHECK("cond low", 1'b0, cond)
        `WAIT_UNTIL(sel === 1'b1)
        `CHECK("auto to b", 1'b1, sel)
        wb(1'b0, prcs_pkg::STAT_OFS, 32'h0);
        `CHECK("status", 5'h13, q[4:0] & 5'h13)
        run_a <= 1'b1;
        repeat (600) @(posedge clk_i);
        `CHECK("fault clears", 1'b0, fault_a)
        `CHECK("no return", 1'b1, sel)
    endtask
    task automatic t_lock();
        do_reset(3);
        lock <= 1'b0;
        `WAIT_UNTIL(sel === 1'b1)
        `CHECK("lock loss", 1'b1, sel)
        @(posedge clk_i);
    endtask
    task automatic t_wait();
        do_reset(3);
        wb(1'b1, prcs_pkg::CTRL_OFS, 32'h0);
        run_b <= 1'b0;
        `WAIT_UNTIL(fault_b === 1'b1)
        `CHECK("fault b", 1'b1, fault_b)
        @(posedge clk_i);
        req <= 1'b1;
        repeat (600) @(posedge clk_i);
        `CHECK("target absent", 1'b0, sel)
        run_b <= 1'b1;
        `WAIT_UNTIL(sel === 1'b1)
        `CHECK("target back", 1'b1, sel)
        @(posedge clk_i);
        req <= 1'b0;
    endtask
    initial begin
        #500000;
        bad_count++;
        give_verdict();
    end
    initial begin
        do_reset(6);
        t_reset();
        t_manual();
        t_auto();
        t_lock();
        t_wait();
        give_verdict();
    end
endmodule
